//--- design/motor_driver_status_regs.sv
/*
 holds the serial target and register bank of the motor driver: status readback, control
 words, configuration words and the commanded-speed selection.
 assumes scl and sda are already synchronous to core_clk_i and much slower than it.
*/
// Behaviour
// - store supply reading on strobe while driving
// - commanded speed is one eight-bit value
// - speed source is pwm, analog or host
// - applied duty readable separately from command
// - answer only device address 0x52
// - seven control words at 0x30 to 0x36
// - status words 0x01-0x08 ignore host writes
// - seven configuration words at 0x90 to 0x96
// - faults clear only on key 0xff write
// - fault bits reset zero, write one clears
`timescale 1ns/1ps
`default_nettype none
module motor_driver_status_regs (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_b_o,
   input wire logic [15:0] fault_event_i,
   input wire motor_regs_pkg::motor_status_t status_i,
   input wire logic [7:0] supply_sample_i,
   input wire logic supply_strobe_i,
   input wire logic driving_i,
   input wire logic analog_mode_i,
   input wire logic [7:0] pwm_duty_i,
   output logic [15:0] fault_flags_o,
   output logic [7:0] commanded_speed_o,
   output logic [8:0] speed_setting_o,
   output logic host_speed_select_o,
   output logic [15:0] nvm_unlock_key_o,
   output logic [motor_regs_pkg::NVM_N-1:0][15:0] nvm_config_o
);
   import motor_regs_pkg::*;

   bank_state_t r;
   bank_state_t n;
   logic scl_rise, scl_fall, start_c, stop_c, wr_fire, clr_hit;
   logic [15:0] wr_word, ev_masked;
   logic [7:0] cur_byte;

   function automatic logic in_win(input logic [7:0] a, input logic [7:0] lo,
                                   input logic [7:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [15:0] read_word(input logic [7:0] a);
      logic [7:0] o;
      o = '0;
      read_word = '0;
      if (a == A_FAULT) begin
         read_word = r.fault;
      end else if (a == A_RATE) begin
         read_word = status_i.rotation_rate;
      end else if (a == A_PERIOD) begin
         read_word = status_i.electrical_period;
      end else if (a == A_KT) begin
         read_word = status_i.back_emf_constant;
      end else if (a == A_CURR) begin
         read_word = {5'h00, status_i.phase_current_reading} & CURR_MASK;
      end else if (a == A_ANGLE_SUP) begin
         read_word = {status_i.start_rotor_angle, r.supply};
      end else if (a == A_DUTY) begin
         read_word = {r.cmd_speed, status_i.applied_duty_value};
      end else if (a == A_INLVL) begin
         read_word = {6'h00, status_i.command_input_sample} & INLVL_MASK;
      end else if (a == A_IDENT) begin
         read_word = {PART_CODE, REV_CODE};
      end else if (in_win(a, A_CTL_FIRST, A_CTL_LAST)) begin
         o = a - A_CTL_FIRST;
         read_word = r.ctl[o[2:0]];
      end else if (in_win(a, A_NVM_FIRST, A_NVM_LAST)) begin
         o = a - A_NVM_FIRST;
         read_word = r.nvm[o[2:0]];
      end
   endfunction

   // **********************************************************************
   // line events
   // **********************************************************************
   assign scl_rise = scl_i && !r.scl_q;
   assign scl_fall = !scl_i && r.scl_q;
   assign start_c = scl_i && r.scl_q && r.sda_q && !sda_i;
   assign stop_c = scl_i && r.scl_q && !r.sda_q && sda_i;
   assign wr_fire = scl_fall && (r.st == S_WLO) && (r.cnt == BIT_LAST);
   assign wr_word = {r.data_hi, r.shift};
   assign clr_hit = wr_fire && (r.reg_addr == A_FAULT) && (r.shift == FAULT_CLR_KEY);
   assign ev_masked = fault_event_i & FAULT_MASK;
   assign cur_byte = r.byte_idx ? r.rd_word[7:0] : r.rd_word[15:8];

   // **********************************************************************
   // next state
   // **********************************************************************
   always_comb begin
      logic [7:0] off;
      logic [15:0] clr;
      off = '0;
      clr = '0;
      n = r;
      n.scl_q = scl_i;
      n.sda_q = sda_i;
      if (start_c) begin
         n.st = S_ADDR;
         n.cnt = CNT_ZERO;
         n.byte_idx = 1'b0;
         n.sda_oe_b = 1'b1;
      end else if (stop_c) begin
         n.st = S_IDLE;
         n.sda_oe_b = 1'b1;
      end else begin
         if (scl_rise) begin
            n.shift = {r.shift[6:0], sda_i};
            n.cnt = r.cnt + CNT_ONE;
         end
         if (scl_fall) begin
            case (r.st)
               S_ADDR, S_REG, S_WHI, S_WLO: begin
                  if (r.cnt == BIT_LAST) begin
                     n.cnt = CNT_ZERO;
                     n.st = S_ACK;
                     n.sda_oe_b = 1'b0;
                     case (r.st)
                        S_ADDR: begin
                           if (r.shift[7:1] == DEV_ADDR) begin
                              n.after = r.shift[0] ? S_RD : S_REG;
                              n.rd_word = read_word(r.reg_addr);
                           end else begin
                              n.st = S_SKIP;
                              n.sda_oe_b = 1'b1;
                           end
                        end
                        S_REG: begin
                           n.reg_addr = r.shift;
                           n.after = S_WHI;
                        end
                        S_WHI: begin
                           n.data_hi = r.shift;
                           n.after = S_WLO;
                        end
                        default: begin
                           n.after = S_SKIP;
                        end
                     endcase
                  end
               end
               S_ACK: begin
                  if (r.cnt == ACK_LAST) begin
                     n.cnt = CNT_ZERO;
                     n.st = r.after;
                     n.sda_oe_b = (r.after == S_RD) ? cur_byte[7] : 1'b1;
                  end
               end
               S_RD: begin
                  if (r.cnt == BIT_LAST) begin
                     n.cnt = CNT_ZERO;
                     n.st = S_MACK;
                     n.sda_oe_b = 1'b1;
                  end else begin
                     n.sda_oe_b = cur_byte[~r.cnt[2:0]];
                  end
               end
               S_MACK: begin
                  if (r.cnt == ACK_LAST) begin
                     n.cnt = CNT_ZERO;
                     if (!r.shift[0] && !r.byte_idx) begin
                        n.byte_idx = 1'b1;
                        n.st = S_RD;
                        n.sda_oe_b = r.rd_word[7];
                     end else begin
                        n.st = S_SKIP;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // only control and configuration words take stored writes
      if (wr_fire) begin
         if (clr_hit) begin
            clr = wr_word;
         end else if (in_win(r.reg_addr, A_CTL_FIRST, A_CTL_LAST)) begin
            off = r.reg_addr - A_CTL_FIRST;
            n.ctl[off[2:0]] = wr_word;
         end else if (in_win(r.reg_addr, A_NVM_FIRST, A_NVM_LAST)) begin
            off = r.reg_addr - A_NVM_FIRST;
            n.nvm[off[2:0]] = wr_word;
         end
      end
      // a fault arriving with the clear stays set
      n.fault = (r.fault & ~clr) | ev_masked;
      if (supply_strobe_i && driving_i) begin
         n.supply = supply_sample_i;
      end
      if (r.ctl[SPEED_IDX][HOST_SEL_BIT]) begin
         n.cmd_speed = r.ctl[SPEED_IDX][SPD_TOP:SPD_LOW];
      end else if (analog_mode_i) begin
         n.cmd_speed = status_i.command_input_sample[IN_TOP:IN_LOW];
      end else begin
         n.cmd_speed = pwm_duty_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= BANK_RESET;
      end else begin
         r <= n;
      end
   end

   assign sda_o = r.sda_o;
   assign sda_oe_b_o = r.sda_oe_b;
   assign fault_flags_o = r.fault;
   assign commanded_speed_o = r.cmd_speed;
   assign speed_setting_o = r.ctl[SPEED_IDX][SPD_MSB:0];
   assign host_speed_select_o = r.ctl[SPEED_IDX][HOST_SEL_BIT];
   assign nvm_unlock_key_o = r.ctl[UNLOCK_IDX];
   assign nvm_config_o = r.nvm;

   // **********************************************************************
   // checks
   // **********************************************************************
   logic [7:0] host_speed;
   assign host_speed = r.ctl[SPEED_IDX][SPD_TOP:SPD_LOW];
   logic addr_done;
   assign addr_done = scl_fall && !start_c && !stop_c && (r.st == S_ADDR) && (r.cnt == BIT_LAST);

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   addr_match_a: assert property (addr_done && r.shift[7:1] == DEV_ADDR |=>
      !sda_oe_b_o && r.st == S_ACK) else $error("own address not acknowledged");
   addr_other_a: assert property (addr_done && r.shift[7:1] != DEV_ADDR |=>
      sda_oe_b_o [*2]) else $error("foreign address acknowledged");
   fault_set_a: assert property (ev_masked != 16'h0000 |=>
      (fault_flags_o & $past(ev_masked)) == $past(ev_masked)) else $error("fault event lost");
   fault_key_a: assert property (wr_fire && !clr_hit |=>
      (fault_flags_o & $past(fault_flags_o)) == $past(fault_flags_o)) else $error("fault lost");
   fault_clear_a: assert property (clr_hit && ev_masked == 16'h0000 |=>
      fault_flags_o == ($past(fault_flags_o) & ~$past(wr_word))) else $error("bad fault clear");
   status_hold_a: assert property (wr_fire && in_win(r.reg_addr, A_RATE, A_IDENT) |=>
      $stable(r.ctl) && $stable(r.nvm)) else $error("status write changed storage");
   ctl_write_a: assert property (wr_fire && r.reg_addr == A_UNLOCK |=>
      nvm_unlock_key_o == $past(wr_word)) else $error("control word not stored");
   nvm_write_a: assert property (wr_fire && r.reg_addr == A_NVM_LAST |=>
      nvm_config_o[NVM_N-1] == $past(wr_word)) else $error("configuration word not stored");
   supply_a: assert property (!(supply_strobe_i && driving_i) |=>
      $stable(r.supply)) else $error("supply changed without a sample");
   host_speed_a: assert property (host_speed_select_o && $stable(host_speed) |=>
      commanded_speed_o == $past(host_speed)) else $error("host speed not selected");
   read_first_a: assert property (scl_fall && !start_c && !stop_c && r.st == S_ACK &&
      r.cnt == ACK_LAST && r.after == S_RD |=> sda_oe_b_o == r.rd_word[15])
      else $error("read did not start with high byte");

   write_c: cover property (wr_fire);
   clear_c: cover property (clr_hit);
   read_two_c: cover property (r.st == S_RD && r.byte_idx);
   foreign_c: cover property (addr_done && r.shift[7:1] != DEV_ADDR);
endmodule // motor_driver_status_regs
`default_nettype wire

//--- design/motor_regs_pkg.sv
/*
 holds constants, register offsets, reset values and types of the motor driver register bank.
 assumes a single 200 MHz core clock and a two-wire serial host outside the device.
*/
package motor_regs_pkg;
   // **********************************************************************
   // serial target and register map
   // **********************************************************************
   localparam logic [6:0] DEV_ADDR = 7'h52;
   localparam logic [7:0] A_FAULT = 8'h00;
   localparam logic [7:0] A_RATE = 8'h01;
   localparam logic [7:0] A_PERIOD = 8'h02;
   localparam logic [7:0] A_KT = 8'h03;
   localparam logic [7:0] A_CURR = 8'h04;
   localparam logic [7:0] A_ANGLE_SUP = 8'h05;
   localparam logic [7:0] A_DUTY = 8'h06;
   localparam logic [7:0] A_INLVL = 8'h07;
   localparam logic [7:0] A_IDENT = 8'h08;
   localparam logic [7:0] A_CTL_FIRST = 8'h30;
   localparam logic [7:0] A_UNLOCK = 8'h31;
   localparam logic [7:0] A_CTL_LAST = 8'h36;
   localparam logic [7:0] A_NVM_FIRST = 8'h90;
   localparam logic [7:0] A_NVM_LAST = 8'h96;
   localparam int CTL_N = 7;
   localparam int NVM_N = 7;
   localparam int SPEED_IDX = 0;
   localparam int UNLOCK_IDX = 1;
   localparam int HOST_SEL_BIT = 15;
   localparam int SPD_MSB = 8;
   localparam int SPD_TOP = 8;
   localparam int SPD_LOW = 1;
   localparam int IN_TOP = 9;
   localparam int IN_LOW = 2;
   // **********************************************************************
   // field masks, keys and reset values
   // **********************************************************************
   localparam logic [15:0] FAULT_MASK = 16'hffbf;
   localparam logic [7:0] FAULT_CLR_KEY = 8'hff;
   localparam logic [15:0] CURR_MASK = 16'h07ff;
   localparam logic [15:0] INLVL_MASK = 16'h03ff;
   localparam logic [NVM_N-1:0][15:0] NVM_RESET = {16'h007a, 16'h7840, 16'h3baf, 16'h3788,
                                                   16'h00c1, 16'h0049, 16'hc000};
   // arbitrary identity values
   localparam logic [7:0] PART_CODE = 8'h5a;
   localparam logic [7:0] REV_CODE = 8'h01;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] ACK_LAST = 4'h1;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   // **********************************************************************
   // types
   // **********************************************************************
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_ADDR = 4'b0001,
      S_REG = 4'b0010,
      S_WHI = 4'b0011,
      S_WLO = 4'b0100,
      S_ACK = 4'b0101,
      S_RD = 4'b0110,
      S_MACK = 4'b0111,
      S_SKIP = 4'b1000
   } link_state_t;

   typedef struct packed {
      logic [15:0] rotation_rate;
      logic [15:0] electrical_period;
      logic [15:0] back_emf_constant;
      logic [10:0] phase_current_reading;
      logic [7:0] start_rotor_angle;
      logic [7:0] applied_duty_value;
      logic [9:0] command_input_sample;
   } motor_status_t;

   typedef struct packed {
      link_state_t st;
      link_state_t after;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic byte_idx;
      logic [15:0] rd_word;
      logic [7:0] reg_addr;
      logic [7:0] data_hi;
      logic scl_q;
      logic sda_q;
      logic sda_oe_b;
      logic sda_o;
      logic [15:0] fault;
      logic [7:0] supply;
      logic [7:0] cmd_speed;
      logic [CTL_N-1:0][15:0] ctl;
      logic [NVM_N-1:0][15:0] nvm;
   } bank_state_t;

   localparam bank_state_t BANK_RESET = '{st: S_IDLE, after: S_IDLE, scl_q: 1'b1, sda_q: 1'b1,
                                          sda_oe_b: 1'b1, nvm: NVM_RESET, default: '0};
endpackage

//--- test/serial_host_model.sv
/*
 host-side serial master model: makes scl and drives sda low or releases it.
 assumes the sda wire is resolved outside with a pull-up and read back on sda_i.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
   import motor_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // ****************
   // bit and byte level
   // ****************
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // data changes only while scl is low; scl high for four clocks, low for at least five
   task automatic bitx(input logic b, output logic r);
      sda_o <= b;
      wt(4);
      scl_o <= 1'b1;
      wt(4);
      r = sda_i;
      scl_o <= 1'b0;
      wt(1);
   endtask

   task automatic start();
      sda_o <= 1'b1;
      wt(4);
      scl_o <= 1'b1;
      wt(4);
      sda_o <= 1'b0;
      wt(4);
      scl_o <= 1'b0;
      wt(4);
   endtask

   task automatic stop();
      sda_o <= 1'b0;
      wt(4);
      scl_o <= 1'b1;
      wt(4);
      sda_o <= 1'b1;
      wt(4);
   endtask

   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(b[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask

   task automatic get(input logic nack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
      bitx(nack, r);
   endtask

   // ****************
   // word transfers
   // ****************
   task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [15:0] d,
                     output logic [3:0] ak);
      start();
      put({dev, 1'b0}, ak[3]);
      put(a, ak[2]);
      put(d[15:8], ak[1]);
      put(d[7:0], ak[0]);
      stop();
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [2:0] ak);
      start();
      put({DEV_ADDR, 1'b0}, ak[2]);
      put(a, ak[1]);
      start();
      put({DEV_ADDR, 1'b1}, ak[0]);
      get(1'b0, d[15:8]);
      get(1'b1, d[7:0]);
      stop();
   endtask
endmodule // serial_host_model
`default_nettype wire

//--- test/motor_driver_status_regs_tb_top.sv
/*
 self-checking bench of the motor driver register bank, driven over the serial link.
 assumes serial_host_model and motor_regs_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module motor_driver_status_regs_tb_top;
   import motor_regs_pkg::*;
   logic clk, rst_b, scl, host_sda, sda_w, sda_o, oe_b, stb, drv, amode, hsel;
   logic [15:0] fev, flags, ukey;
   logic [7:0] sup, pwm, cmd;
   logic [8:0] spd;
   logic [NVM_N-1:0][15:0] nvm;
   motor_status_t st;
   int err_count, tests_run;
   logic [15:0] nv [7] = '{16'hc000, 16'h0049, 16'h00c1, 16'h3788, 16'h3baf, 16'h7840,
                           16'h007a};
   logic [3:0] ak;

   assign sda_w = (oe_b === 1'b0) ? 1'b0 : host_sda;

   motor_driver_status_regs dut (.core_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_b_o(oe_b), .fault_event_i(fev), .status_i(st),
      .supply_sample_i(sup), .supply_strobe_i(stb), .driving_i(drv), .analog_mode_i(amode),
      .pwm_duty_i(pwm), .fault_flags_o(flags), .commanded_speed_o(cmd),
      .speed_setting_o(spd), .host_speed_select_o(hsel), .nvm_unlock_key_o(ukey),
      .nvm_config_o(nvm));

   serial_host_model host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));

   // ****************
   // tasks
   // ****************
   task automatic results();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic rw(input logic [7:0] a, input logic [15:0] d);
      logic [3:0] k;
      host.wr(DEV_ADDR, a, d, k);
      `CHK(k, 4'hf)
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic [2:0] k;
      host.rd(a, d, k);
      `CHK(k, 3'h7)
      `CHK(d, e)
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      results();
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      rst_b = 1'b0;
      fev = '0;
      sup = 8'h00;
      stb = 1'b0;
      drv = 1'b0;
      amode = 1'b0;
      pwm = 8'h3c;
      st = '{16'h1234, 16'h5678, 16'h9abc, 11'h5a5, 8'h2b, 8'h66, 10'h2c4};
      repeat (6) @(posedge clk);
      `CHK(flags, 16'h0000)
      rst_b <= 1'b1;
      host.wt(3);
      for (int i = 0; i < 7; i++) rchk(8'h90 + 8'(i), nv[i]);
      for (int i = 0; i < 7; i++) rw(8'h30 + 8'(i), 16'(16'h1111 * (i + 1)));
      for (int i = 0; i < 7; i++) rchk(8'h30 + 8'(i), 16'(16'h1111 * (i + 1)));
      `CHK(ukey, 16'h2222)
      `CHK({hsel, spd}, 10'h111)
      `CHK(cmd, 8'h3c)
      pwm <= 8'h7e;
      host.wt(3);
      `CHK(cmd, 8'h7e)
      amode <= 1'b1;
      host.wt(3);
      `CHK(cmd, 8'hb1)
      rw(A_CTL_FIRST, 16'h81a5);
      `CHK({hsel, spd}, 10'h3a5)
      `CHK(cmd, 8'hd2)
      rchk(A_DUTY, 16'hd266);
      st.applied_duty_value <= 8'h99;
      host.wt(2);
      rchk(A_DUTY, 16'hd299);
      sup <= 8'h9c;
      drv <= 1'b1;
      stb <= 1'b1;
      host.wt(1);
      sup <= 8'h11;
      drv <= 1'b0;
      host.wt(1);
      stb <= 1'b0;
      drv <= 1'b1;
      host.wt(2);
      drv <= 1'b0;
      rchk(A_ANGLE_SUP, 16'h2b9c);
      rchk(A_RATE, 16'h1234);
      rchk(A_PERIOD, 16'h5678);
      rchk(A_KT, 16'h9abc);
      rchk(A_CURR, 16'h05a5);
      rchk(A_INLVL, 16'h02c4);
      rchk(A_IDENT, {PART_CODE, REV_CODE});
      rw(A_RATE, 16'h0000);
      rchk(A_RATE, 16'h1234);
      rchk(8'h20, 16'h0000);
      fev <= 16'hffff;
      host.wt(1);
      fev <= 16'h0000;
      host.wt(2);
      `CHK(flags, 16'hffbf)
      rw(A_FAULT, 16'h0f0f);
      `CHK(flags, 16'hffbf)
      rw(A_FAULT, 16'h00ff);
      rchk(A_FAULT, 16'hff00);
      rw(A_FAULT, 16'hffff);
      `CHK(flags, 16'h0000)
      host.wr(7'h53, A_UNLOCK, 16'hdead, ak);
      `CHK(ak, 4'h0)
      `CHK(ukey, 16'h2222)
      `CHK(sda_o, 1'b0)
      rw(A_NVM_LAST, 16'h1357);
      `CHK(nvm[NVM_N-1], 16'h1357)
      rchk(A_NVM_LAST, 16'h1357);
      // mid-run reset brings back the configuration defaults and clears control words
      rst_b <= 1'b0;
      host.wt(2);
      `CHK(ukey, 16'h0000)
      `CHK(nvm[NVM_N-1], nv[6])
      `CHK(flags, 16'h0000)
      rst_b <= 1'b1;
      host.wt(3);
      rchk(A_NVM_LAST, nv[6]);
      results();
   end
endmodule // motor_driver_status_regs_tb_top
`default_nettype wire
